// File: fepsq_bus_cycle.sv
// single flash bus cycle: one write strobe or one read with data capture
// assumes: flash pins are driven from here only; data bus input is asynchronous
module fepsq_bus_cycle
	import fepsq_pkg::*;
(
	// system
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	// request
	input wire logic start_in,
	input wire logic read_in,
	input wire fepsq_cyc_t cyc_in,
	// flash side
	input wire logic [7:0] dq_in,
	output fepsq_pins_t pins_out,
	// answer
	output logic [7:0] rdata_out,
	output logic done_out
);

	// ****************************************
	// data bus synchroniser
	// ****************************************
	logic [7:0] dq_meta_q;
	logic [7:0] dq_sync_q;
	logic [3:0] cnt_q;
	logic active_q;
	logic rd_q;

	// two stages before the capture register looks at the pins
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
		if (!arst_n_in)
		begin
			dq_meta_q <= 8'h00;
			dq_sync_q <= 8'h00;
		end
		else
		begin
			dq_meta_q <= dq_in;
			dq_sync_q <= dq_meta_q;
		end

	// ****************************************
	// strobe timing
	// ****************************************
	// write: we low for one cycle more than the pulse count, then one hold cycle with data still driven
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
		if (!arst_n_in)
		begin
			pins_out <= FEPSQ_PINS_IDLE;
			cnt_q <= 4'h0;
			active_q <= 1'b0;
			rd_q <= 1'b0;
			done_out <= 1'b0;
			rdata_out <= 8'h00;
		end
		else
		begin
			done_out <= 1'b0;
			if (start_in && !active_q)
			begin
				active_q <= 1'b1;
				rd_q <= read_in;
				pins_out.addr <= cyc_in.addr;
				pins_out.dq <= cyc_in.data;
				pins_out.dq_oe_n <= read_in;
				pins_out.ce_n <= 1'b0;
				pins_out.we_n <= read_in;
				pins_out.oe_n <= !read_in;
				// read waits out the access time plus the synchroniser latency
				cnt_q <= read_in ? 4'(FEPSQ_READ_CYC + FEPSQ_SYNC_STAGES) : 4'(FEPSQ_WE_CYC + 1);
			end
			else if (active_q)
			begin
				if (cnt_q == 4'h1)
					pins_out.we_n <= 1'b1;
				if (cnt_q != 4'h0)
					cnt_q <= cnt_q - 4'h1;
				else
				begin
					pins_out <= FEPSQ_PINS_IDLE;
					active_q <= 1'b0;
					done_out <= 1'b1;
					if (rd_q)
						rdata_out <= dq_sync_q;
				end
			end
		end

endmodule : fepsq_bus_cycle

// File: fepsq_flash_model.sv
// flash chip model: decodes unlocked command cycles and keeps a sparse byte array
// assumes: strobes come from the sequencer, registered on the same clock
module fepsq_flash_model #(
	parameter int SECT_CYC = 60,
	parameter int CHIP_CYC = 120,
	parameter int PROG_CYC = 10
)(
	// system
	input wire logic clk_sys_in,
	// flash pins
	input wire logic [20:0] addr_in,
	input wire logic [7:0] dq_in,
	input wire logic ce_n_in,
	input wire logic we_n_in,
	input wire logic oe_n_in,
	input wire logic rst_n_in,
	output logic [7:0] dq_out,
	output logic ready_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [int];
	logic [20:0] ha [0:5];
	logic [7:0] hd [0:5];
	logic we_q;
	int busy;
	int ks [$];

	// erased bytes read all ones
	function automatic logic [7:0] peek(input logic [20:0] a);
		return mem.exists(int'(a)) ? mem[int'(a)] : 8'hFF;
	endfunction : peek

	// unlock pair at history slot k
	function automatic bit unl(input int k);
		return ha[k] == 21'h000555 && hd[k] == 8'hAA && ha[k + 1] == 21'h0002AA && hd[k + 1] == 8'h55;
	endfunction : unl

	initial
	begin
		dq_out = 8'h00;
		ready_out = 1'b1;
		we_q = 1'b1;
		busy = 0;
	end

	// ****************************************
	// command capture, busy timing, read drive
	// ****************************************
	// cycles seen while busy are dropped, like the real part
	always @(posedge clk_sys_in)
	begin
		we_q <= we_n_in;
		if (!rst_n_in)
			busy = 0;
		else if (busy > 0)
			busy = busy - 1;
		else if (we_n_in && !we_q && !ce_n_in)
		begin
			for (int i = 0; i < 5; i++)
			begin
				ha[i] = ha[i + 1];
				hd[i] = hd[i + 1];
			end
			ha[5] = addr_in;
			hd[5] = dq_in;
			if (unl(0) && hd[2] == 8'h80 && unl(3) && hd[5] == 8'h30)
			begin
				ks.delete();
				foreach (mem[k])
					if (k[20:16] == ha[5][20:16]) ks.push_back(k);
				foreach (ks[i])
					mem.delete(ks[i]);
				busy = SECT_CYC;
			end
			else if (unl(0) && hd[2] == 8'h80 && unl(3) && hd[5] == 8'h10)
			begin
				mem.delete();
				busy = CHIP_CYC;
			end
			else if (unl(2) && hd[4] == 8'hA0)
			begin
				mem[int'(ha[5])] = peek(ha[5]) & hd[5];
				busy = PROG_CYC;
			end
		end
		ready_out <= (busy == 0);
		// released bus toggles so a stale value never looks valid
		dq_out <= (!ce_n_in && !oe_n_in) ? peek(addr_in) : ~dq_out;
	end
endmodule : fepsq_flash_model

// File: fepsq_pkg.sv
// package: register offsets, field positions, timing counts and carrier types
// assumes: one 50 MHz system clock and an 8-bit register data path
package fepsq_pkg;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [15:0] FEPSQ_STATUS_OFS = 16'h2800;
	localparam logic [15:0] FEPSQ_FREAD_OFS = 16'h3800;
	localparam logic [15:0] FEPSQ_FRESET_OFS = 16'h4000;
	localparam logic [15:0] FEPSQ_PROG_OFS = 16'h4800;
	localparam logic [15:0] FEPSQ_SECT_OFS = 16'h5000;
	localparam logic [15:0] FEPSQ_CHIP_OFS = 16'h5800;
	localparam logic [15:0] FEPSQ_DATA_OFS = 16'h6000;
	localparam logic [15:0] FEPSQ_ADDR_LO_OFS = 16'h6800;
	localparam logic [15:0] FEPSQ_ADDR_MID_OFS = 16'h7000;
	localparam logic [15:0] FEPSQ_ADDR_HI_OFS = 16'h7800;

	// ****************************************
	// fields and reset values
	// ****************************************
	localparam int FEPSQ_GO_BIT = 0;
	localparam int FEPSQ_BUSY_BIT = 0;
	localparam int FEPSQ_TOUT_BIT = 1;
	localparam int FEPSQ_HI_W = 5;
	localparam int FEPSQ_SECT_LSB = 16;
	localparam logic [7:0] FEPSQ_BYTE_RST = 8'h00;
	localparam logic [4:0] FEPSQ_HI_RST = 5'h00;

	// ****************************************
	// timing
	// ****************************************
	localparam int FEPSQ_CLK_NS = 20;
	localparam int FEPSQ_SECTOR_ERASE_MS = 700;
	localparam int FEPSQ_CHIP_ERASE_MS = 14000;
	localparam int FEPSQ_PROGRAM_LIMIT_US = 1000;
	localparam int FEPSQ_WE_PULSE_NS = 60;
	localparam int FEPSQ_READ_ACCESS_NS = 90;
	localparam int FEPSQ_BUSY_SETTLE_NS = 500;
	localparam int FEPSQ_SYNC_STAGES = 2;
	localparam int FEPSQ_SECTOR_ERASE_CYC = FEPSQ_SECTOR_ERASE_MS * (1000000 / FEPSQ_CLK_NS);
	localparam int FEPSQ_CHIP_ERASE_CYC = FEPSQ_CHIP_ERASE_MS * (1000000 / FEPSQ_CLK_NS);
	localparam int FEPSQ_PROGRAM_CYC = FEPSQ_PROGRAM_LIMIT_US * (1000 / FEPSQ_CLK_NS);
	localparam int FEPSQ_WE_CYC = (FEPSQ_WE_PULSE_NS + FEPSQ_CLK_NS - 1) / FEPSQ_CLK_NS;
	localparam int FEPSQ_READ_CYC = (FEPSQ_READ_ACCESS_NS + FEPSQ_CLK_NS - 1) / FEPSQ_CLK_NS;
	localparam int FEPSQ_SETTLE_CYC = (FEPSQ_BUSY_SETTLE_NS + FEPSQ_CLK_NS - 1) / FEPSQ_CLK_NS;

	// ****************************************
	// flash command bytes
	// ****************************************
	localparam logic [20:0] FEPSQ_UNLOCK1_ADDR = 21'h000555;
	localparam logic [20:0] FEPSQ_UNLOCK2_ADDR = 21'h0002AA;
	localparam logic [7:0] FEPSQ_UNLOCK1_DATA = 8'hAA;
	localparam logic [7:0] FEPSQ_UNLOCK2_DATA = 8'h55;
	localparam logic [7:0] FEPSQ_ERASE_SETUP = 8'h80;
	localparam logic [7:0] FEPSQ_PROG_SETUP = 8'hA0;
	localparam logic [7:0] FEPSQ_SECT_CONFIRM = 8'h30;
	localparam logic [7:0] FEPSQ_CHIP_CONFIRM = 8'h10;
	localparam logic [7:0] FEPSQ_RESET_CMD = 8'hF0;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [5:0] {
		OP_NONE = 6'b000001,
		OP_PROG = 6'b000010,
		OP_SECT = 6'b000100,
		OP_CHIP = 6'b001000,
		OP_RST = 6'b010000,
		OP_READ = 6'b100000
	} fepsq_op_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_ISSUE = 4'b0010,
		ST_CYCLE = 4'b0100,
		ST_WAIT = 4'b1000
	} fepsq_state_t;

	typedef struct packed {
		logic [20:0] addr;
		logic [7:0] data;
	} fepsq_cyc_t;

	typedef struct packed {
		logic [20:0] addr;
		logic [7:0] dq;
		logic dq_oe_n;
		logic ce_n;
		logic we_n;
		logic oe_n;
	} fepsq_pins_t;

	localparam fepsq_pins_t FEPSQ_PINS_IDLE = '{addr: 21'h000000, dq: 8'h00, dq_oe_n: 1'b1,
		ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};

endpackage : fepsq_pkg

// File: fepsq_top.sv
// flash erase / program sequencer: register decode, command sequences, busy tracking
// assumes: register strobes are synchronous to clk_sys_in; flash ready pin is asynchronous
//
// Notes on behaviour
// (R1) sector-erase register bit 0 starts erase
// (R2) software checks idle before new operation
// (R3) thirty-two sectors, chosen by top five lines
// (R4) sector lines come from upper address register
// (R5) sector erase touches selected sector only
// (R6) programming clears bits; erase before reprogram
// (R7) sector erase about 0.7 s, busy throughout
// (R8) status bit 0 reads zero when done
// (R9) other commands ignored during sector erase
// (R10) hardware reset aborts sector erase at once
// (R11) chip-erase register bit 0 erases everything
// (R12) chip erase about 14 s, busy throughout
// (R13) other commands ignored during chip erase
// (R14) hardware reset aborts chip erase at once
// (R15) data byte held; low nibble reads back
// (R16) low address register gives bits 7-0
// (R17) middle address register gives bits 15-8
// (R18) upper register gives bits 20-16, three unused
// (R19) program-start writes held byte at address
// (R20) flash-read register reads at held address
// (R21) reset command ignored while operation runs
// (R22) busy while configuration-stop bit is zero
// (R23) busy from command acceptance until completion
module fepsq_top
	import fepsq_pkg::*;
#(
	parameter int unsigned SECTOR_ERASE_LIMIT = FEPSQ_SECTOR_ERASE_CYC,
	parameter int unsigned CHIP_ERASE_LIMIT = FEPSQ_CHIP_ERASE_CYC,
	parameter int unsigned PROGRAM_LIMIT = FEPSQ_PROGRAM_CYC
)(
	// system
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	// register port
	input wire logic [15:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	output logic reg_rvalid_out,
	// configuration hand-off
	input wire logic cfg_stop_in,
	// flash pins
	output logic [20:0] flash_addr_out,
	input wire logic [7:0] flash_dq_in,
	output logic [7:0] flash_dq_out,
	output logic flash_dq_oe_n_out,
	output logic flash_ce_n_out,
	output logic flash_we_n_out,
	output logic flash_oe_n_out,
	output logic flash_rst_n_out,
	input wire logic flash_ready_in
);

	// ****************************************
	// declarations
	// ****************************************
	fepsq_state_t state_q;
	fepsq_op_t op_q;
	fepsq_op_t req_op;
	fepsq_cyc_t step_cyc;
	fepsq_pins_t pins;
	logic [2:0] step_q;
	logic [31:0] wait_q;
	logic [31:0] limit;
	logic [7:0] data_q;
	logic [7:0] addr_lo_q;
	logic [7:0] addr_mid_q;
	logic [4:0] addr_hi_q;
	logic tout_q;
	logic rdy_meta_q;
	logic rdy_q;
	logic [1:0] rst_pipe_q;
	logic accept;
	logic busy;
	logic cyc_done;
	logic [7:0] cyc_rdata;
	logic [20:0] held_addr;

	// ****************************************
	// decode helpers
	// ****************************************
	// write decode of the command registers
	function automatic fepsq_op_t wr_cmd_op(input logic [15:0] a);
		case (a)
			FEPSQ_PROG_OFS: return OP_PROG;
			FEPSQ_SECT_OFS: return OP_SECT;
			FEPSQ_CHIP_OFS: return OP_CHIP;
			FEPSQ_FRESET_OFS: return OP_RST;
			default: return OP_NONE;
		endcase
	endfunction : wr_cmd_op

	// index of the final bus cycle of each sequence
	function automatic logic [2:0] last_step(input fepsq_op_t op);
		case (op)
			OP_PROG: return 3'd3;
			OP_SECT: return 3'd5;
			OP_CHIP: return 3'd5;
			default: return 3'd0;
		endcase
	endfunction : last_step

	// address/data of one bus cycle of a sequence
	function automatic fepsq_cyc_t seq_cyc(input fepsq_op_t op, input logic [2:0] idx,
		input logic [20:0] a, input logic [7:0] d);
		fepsq_cyc_t c;
		c = '{addr: FEPSQ_UNLOCK1_ADDR, data: FEPSQ_UNLOCK1_DATA};
		if (op == OP_READ)
			c = '{addr: a, data: 8'h00}; // R20
		else if (op == OP_RST)
			c.data = FEPSQ_RESET_CMD;
		else
			case (idx)
				3'd1: c = '{addr: FEPSQ_UNLOCK2_ADDR, data: FEPSQ_UNLOCK2_DATA};
				3'd2: c.data = (op == OP_PROG) ? FEPSQ_PROG_SETUP : FEPSQ_ERASE_SETUP;
				3'd3: if (op == OP_PROG) c = '{addr: a, data: d}; // R19
				3'd4: c = '{addr: FEPSQ_UNLOCK2_ADDR, data: FEPSQ_UNLOCK2_DATA};
				3'd5:
				begin
					// only the sector lines reach the chip; lower lines are zero
					if (op == OP_SECT)
						c = '{addr: {a[20:FEPSQ_SECT_LSB], 16'h0000}, data: FEPSQ_SECT_CONFIRM}; // R3 R5
					else
						c.data = FEPSQ_CHIP_CONFIRM;
				end
				default: c = c;
			endcase
		return c;
	endfunction : seq_cyc

	// ****************************************
	// synchronisers and flash reset
	// ****************************************
	// ready/busy pin is asynchronous to the system clock
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
		if (!arst_n_in)
		begin
			rdy_meta_q <= 1'b0;
			rdy_q <= 1'b0;
		end
		else
		begin
			rdy_meta_q <= flash_ready_in;
			rdy_q <= rdy_meta_q;
		end

	// chip reset pin follows the board reset so a running erase stops with it
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
		if (!arst_n_in)
			rst_pipe_q <= 2'b00; // R10 R14
		else
			rst_pipe_q <= {rst_pipe_q[0], 1'b1};

	assign flash_rst_n_out = rst_pipe_q[1];

	// ****************************************
	// command acceptance
	// ****************************************
	always_comb
	begin
		req_op = OP_NONE;
		if (reg_wr_in && reg_wdata_in[FEPSQ_GO_BIT])
			req_op = wr_cmd_op(reg_addr_in); // R1 R11 R19
		else if (reg_rd_in && reg_addr_in == FEPSQ_FREAD_OFS)
			req_op = OP_READ; // R20
	end

	// refused outright while a sequence runs or configuration owns the chip
	assign accept = (state_q == ST_IDLE) && cfg_stop_in && (req_op != OP_NONE); // R9 R13 R21 R22
	assign busy = !cfg_stop_in || (state_q != ST_IDLE); // R22 R23 R7 R12
	assign held_addr = {addr_hi_q, addr_mid_q, addr_lo_q}; // R4 R16 R17 R18
	assign step_cyc = seq_cyc(op_q, step_q, held_addr, data_q);

	// ****************************************
	// held data and address registers
	// ****************************************
	// locked while a sequence runs so the byte in flight cannot change under it
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
		if (!arst_n_in)
		begin
			data_q <= FEPSQ_BYTE_RST;
			addr_lo_q <= FEPSQ_BYTE_RST;
			addr_mid_q <= FEPSQ_BYTE_RST;
			addr_hi_q <= FEPSQ_HI_RST;
		end
		else if (reg_wr_in && state_q == ST_IDLE)
			case (reg_addr_in)
				FEPSQ_DATA_OFS: data_q <= reg_wdata_in; // R15
				FEPSQ_ADDR_LO_OFS: addr_lo_q <= reg_wdata_in; // R16
				FEPSQ_ADDR_MID_OFS: addr_mid_q <= reg_wdata_in; // R17
				FEPSQ_ADDR_HI_OFS: addr_hi_q <= reg_wdata_in[FEPSQ_HI_W-1:0]; // R18
				default: data_q <= data_q;
			endcase

	// ****************************************
	// sequencer
	// ****************************************
	always_comb
	begin
		case (op_q)
			OP_SECT: limit = SECTOR_ERASE_LIMIT; // R7
			OP_CHIP: limit = CHIP_ERASE_LIMIT; // R12
			OP_PROG: limit = PROGRAM_LIMIT;
			default: limit = 32'(FEPSQ_SETTLE_CYC);
		endcase
	end

	// issue each bus cycle, then, except after a flash read, hold busy until the chip reports ready or the limit runs out
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
		if (!arst_n_in)
		begin
			state_q <= ST_IDLE;
			op_q <= OP_NONE;
			step_q <= 3'd0;
			wait_q <= 32'h00000000;
		end
		else
			case (state_q)
				ST_IDLE:
				begin
					if (accept)
					begin
						state_q <= ST_ISSUE; // R23
						op_q <= req_op;
						step_q <= 3'd0;
					end
				end
				ST_ISSUE:
					state_q <= ST_CYCLE;
				ST_CYCLE:
				begin
					if (cyc_done)
					begin
						wait_q <= 32'h00000000;
						if (step_q != last_step(op_q))
						begin
							step_q <= step_q + 3'd1;
							state_q <= ST_ISSUE;
						end
						else if (op_q == OP_READ)
							state_q <= ST_IDLE;
						else
							state_q <= ST_WAIT;
					end
				end
				ST_WAIT:
				begin
					wait_q <= wait_q + 32'h00000001;
					// the chip needs a moment to pull ready low after the last cycle
					if ((wait_q >= 32'(FEPSQ_SETTLE_CYC) && rdy_q) || wait_q >= limit)
						state_q <= ST_IDLE; // R8
				end
				default:
					state_q <= ST_IDLE;
			endcase

	// timeout flag: cleared on a new command, set when the chip never reports ready
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
		if (!arst_n_in)
			tout_q <= 1'b0;
		else if (state_q == ST_WAIT && wait_q >= limit && !(wait_q >= 32'(FEPSQ_SETTLE_CYC) && rdy_q))
			tout_q <= 1'b1;
		else if (accept)
			tout_q <= 1'b0;

	// ****************************************
	// flash bus cycle engine
	// ****************************************
	fepsq_bus_cycle u_cycle (
		.clk_sys_in(clk_sys_in),
		.arst_n_in(arst_n_in),
		.start_in(state_q == ST_ISSUE),
		.read_in(op_q == OP_READ),
		.cyc_in(step_cyc),
		.dq_in(flash_dq_in),
		.pins_out(pins),
		.rdata_out(cyc_rdata),
		.done_out(cyc_done)
	);

	assign flash_addr_out = pins.addr;
	assign flash_dq_out = pins.dq;
	assign flash_dq_oe_n_out = pins.dq_oe_n;
	assign flash_ce_n_out = pins.ce_n;
	assign flash_we_n_out = pins.we_n;
	assign flash_oe_n_out = pins.oe_n;

	// ****************************************
	// register read answers
	// ****************************************
	// one read outstanding at a time; a flash read answers when its cycle ends
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
		if (!arst_n_in)
		begin
			reg_rdata_out <= 8'h00;
			reg_rvalid_out <= 1'b0;
		end
		else
		begin
			reg_rvalid_out <= 1'b0;
			if (state_q == ST_CYCLE && cyc_done && op_q == OP_READ)
			begin
				reg_rdata_out <= cyc_rdata; // R20
				reg_rvalid_out <= 1'b1;
			end
			else if (reg_rd_in && !(accept && req_op == OP_READ))
			begin
				reg_rvalid_out <= 1'b1;
				case (reg_addr_in)
					FEPSQ_STATUS_OFS: reg_rdata_out <= {6'h00, tout_q, busy}; // R8 R22
					FEPSQ_DATA_OFS: reg_rdata_out <= {4'h0, data_q[3:0]}; // R15
					default: reg_rdata_out <= 8'h00;
				endcase
			end
		end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!arst_n_in);

	sequence s_accept(fepsq_op_t op);
		accept && req_op == op;
	endsequence

	sequence s_started(fepsq_op_t op);
		state_q == ST_ISSUE && op_q == op && step_q == 3'd0;
	endsequence

	AST_SECTOR_START: assert property (s_accept(OP_SECT) |=> s_started(OP_SECT)) // R1
		else $error("sector erase not started");
	AST_CHIP_START: assert property (s_accept(OP_CHIP) |=> s_started(OP_CHIP)) // R11
		else $error("chip erase not started");
	AST_SECTOR_ADDR: assert property (state_q == ST_ISSUE && op_q == OP_SECT && step_q == 3'd5 // R3 R4 R5
		|=> flash_addr_out == {addr_hi_q, 16'h0000} && flash_dq_out == FEPSQ_SECT_CONFIRM)
		else $error("sector address wrong");
	AST_PROG_TARGET: assert property (state_q == ST_ISSUE && op_q == OP_PROG && step_q == 3'd3 // R19
		|=> flash_addr_out == held_addr && flash_dq_out == data_q && !flash_we_n_out)
		else $error("program cycle wrong");
	AST_LOCKED: assert property (state_q != ST_IDLE && reg_wr_in // R9 R13 R21
		|=> $stable(op_q) && $stable(held_addr) && $stable(data_q)
			&& (state_q != ST_IDLE || $past(state_q) inside {ST_WAIT, ST_CYCLE}))
		else $error("command taken while busy");
	AST_STOP_BUSY: assert property (reg_rd_in && reg_addr_in == FEPSQ_STATUS_OFS && !cfg_stop_in // R22
		|=> reg_rvalid_out && reg_rdata_out[FEPSQ_BUSY_BIT])
		else $error("busy not shown while stopped");
	AST_BUSY_HELD: assert property (s_accept(OP_SECT) or s_accept(OP_CHIP) // R7 R12 R23
		|=> busy [*8])
		else $error("busy dropped early");
	AST_DONE_READY: assert property (state_q == ST_WAIT && wait_q >= 32'(FEPSQ_SETTLE_CYC) && rdy_q // R8
		|=> state_q == ST_IDLE ##0 (cfg_stop_in -> !busy))
		else $error("ready not reported");
	AST_NIBBLE: assert property (reg_rd_in && reg_addr_in == FEPSQ_DATA_OFS // R15
		|=> reg_rvalid_out && reg_rdata_out == {4'h0, $past(data_q[3:0])})
		else $error("data readback wrong");
	AST_READ_CYCLE: assert property (s_accept(OP_READ) |=> ##1 flash_addr_out == held_addr && !flash_oe_n_out) // R20
		else $error("flash read not issued");

endmodule : fepsq_top

// File: tb_fepsq_top.sv
// testbench: register-level sequences against the sequencer and a flash model
// assumes: shortened timeout parameters; model erase times stay below them
module tb_fepsq_top
	import fepsq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, arst_n, reg_wr, reg_rd, reg_rvalid, cfg_stop;
	logic [15:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, fdq_o, fdq_i;
	logic [20:0] faddr;
	logic fdq_oe_n, fce_n, fwe_n, foe_n, frst_n, fready;
	int fails, checked;
	logic [15:0] cmd [2];

	fepsq_top #(.SECTOR_ERASE_LIMIT(200), .CHIP_ERASE_LIMIT(400), .PROGRAM_LIMIT(100)) DUT (
		.clk_sys_in(clk_sys), .arst_n_in(arst_n), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
		.reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .reg_rvalid_out(reg_rvalid),
		.cfg_stop_in(cfg_stop), .flash_addr_out(faddr), .flash_dq_in(fdq_i), .flash_dq_out(fdq_o),
		.flash_dq_oe_n_out(fdq_oe_n), .flash_ce_n_out(fce_n), .flash_we_n_out(fwe_n),
		.flash_oe_n_out(foe_n), .flash_rst_n_out(frst_n), .flash_ready_in(fready));

	fepsq_flash_model flash (.clk_sys_in(clk_sys), .addr_in(faddr), .dq_in(fdq_o), .ce_n_in(fce_n),
		.we_n_in(fwe_n), .oe_n_in(foe_n), .rst_n_in(frst_n), .dq_out(fdq_i), .ready_out(fready));

	// ****************************************
	// clock, access tasks, compare, verdict
	// ****************************************
	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk_sys);
		reg_wr = 1'b0;
	endtask : wr

	// one read outstanding; address held until the answer
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk_sys);
		reg_rd = 1'b0;
		d = 8'hXX;
		// answer is a one-cycle pulse: look at every falling edge, the first one included
		repeat (40)
		begin
			if (reg_rvalid === 1'b1)
			begin
				d = reg_rdata;
				break;
			end
			@(negedge clk_sys);
		end
	endtask : rd

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic ck_rd(input string nm, input logic [15:0] a, input logic [7:0] e);
		logic [7:0] v;
		rd(a, v);
		chk(nm, e, v);
	endtask : ck_rd

	task automatic set_addr(input logic [7:0] h, input logic [7:0] m, input logic [7:0] l);
		wr(FEPSQ_ADDR_HI_OFS, h);
		wr(FEPSQ_ADDR_MID_OFS, m);
		wr(FEPSQ_ADDR_LO_OFS, l);
	endtask : set_addr

	// polls until ready; a set timeout bit also shows as a mismatch
	task automatic wait_idle();
		logic [7:0] s;
		repeat (300)
		begin
			rd(FEPSQ_STATUS_OFS, s);
			if (s[FEPSQ_BUSY_BIT] === 1'b0)
				break;
		end
		chk("status idle", 8'h00, s);
	endtask : wait_idle

	task automatic wrap_up();
		$display("checks %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up

	// whole run is under a thousand cycles
	initial
	begin
		repeat (30000) @(posedge clk_sys);
		fails++;
		wrap_up();
	end

	// ****************************************
	// test sequence
	// ****************************************
	initial
	begin
		{arst_n, reg_wr, reg_rd, cfg_stop, reg_addr, reg_wdata} = '0;
		fails = 0;
		checked = 0;
		cmd = '{FEPSQ_SECT_OFS, FEPSQ_CHIP_OFS};
		repeat (12) @(negedge clk_sys);
		arst_n = 1'b1;
		ck_rd("busy while config owns flash", FEPSQ_STATUS_OFS, 8'h01);
		cfg_stop = 1'b1;
		wait_idle();
		wr(FEPSQ_FRESET_OFS, 8'h01);
		ck_rd("busy during flash reset", FEPSQ_STATUS_OFS, 8'h01);
		wait_idle();
		wr(FEPSQ_DATA_OFS, 8'hA5);
		ck_rd("data low nibble", FEPSQ_DATA_OFS, 8'h05);
		ck_rd("unmapped offset", 16'h1000, 8'h00);
		set_addr(8'hF2, 8'h34, 8'h56);
		wr(FEPSQ_DATA_OFS, 8'h5A);
		wr(FEPSQ_PROG_OFS, 8'h01);
		ck_rd("busy at accept", FEPSQ_STATUS_OFS, 8'h01);
		wait_idle();
		ck_rd("programmed byte", FEPSQ_FREAD_OFS, 8'h5A);
		wr(FEPSQ_DATA_OFS, 8'hF0);
		wr(FEPSQ_PROG_OFS, 8'h01);
		wait_idle();
		ck_rd("program clears only", FEPSQ_FREAD_OFS, 8'h50);
		set_addr(8'h03, 8'h00, 8'h00);
		wr(FEPSQ_DATA_OFS, 8'h11);
		wr(FEPSQ_PROG_OFS, 8'h01);
		wait_idle();
		set_addr(8'h12, 8'h00, 8'h00);
		wr(FEPSQ_SECT_OFS, 8'hFE);
		ck_rd("bit0 clear no start", FEPSQ_STATUS_OFS, 8'h00);
		wr(FEPSQ_SECT_OFS, 8'h01);
		wr(FEPSQ_CHIP_OFS, 8'h01);
		wr(FEPSQ_FRESET_OFS, 8'h01);
		wr(FEPSQ_ADDR_HI_OFS, 8'h03);
		ck_rd("sector erase busy", FEPSQ_STATUS_OFS, 8'h01);
		wait_idle();
		set_addr(8'h12, 8'h34, 8'h56);
		ck_rd("sector erased", FEPSQ_FREAD_OFS, 8'hFF);
		set_addr(8'h03, 8'h00, 8'h00);
		ck_rd("other sector kept", FEPSQ_FREAD_OFS, 8'h11);
		wr(FEPSQ_CHIP_OFS, 8'h01);
		wr(FEPSQ_SECT_OFS, 8'h01);
		repeat (60) @(negedge clk_sys);
		ck_rd("chip erase busy", FEPSQ_STATUS_OFS, 8'h01);
		wait_idle();
		ck_rd("chip erased", FEPSQ_FREAD_OFS, 8'hFF);
		// hardware reset in mid-erase, both erase kinds
		// wait past the six command cycles so the chip is really erasing when reset hits
		foreach (cmd[i])
		begin
			wr(cmd[i], 8'h01);
			repeat (60) @(negedge clk_sys);
			arst_n = 1'b0;
			repeat (2) @(negedge clk_sys);
			chk("pins in reset", 8'h37, {2'b00, fdq_oe_n, fready, frst_n, fce_n, fwe_n, foe_n});
			arst_n = 1'b1;
			ck_rd("idle after abort", FEPSQ_STATUS_OFS, 8'h00);
		end
		wrap_up();
	end
endmodule : tb_fepsq_top
